// ===== design/wfl_pkg.sv
// Package: constants and types for the waveform file loader
package wfl_pkg;
  // Serial link timing
  localparam int unsigned WFL_CLK_HZ  = 40_000_000;       // System clock rate
  localparam int unsigned WFL_BAUD    = 9600;             // Link rate in baud
  localparam int unsigned WFL_BIT_CYC = WFL_CLK_HZ / WFL_BAUD; // Cycles per bit
  // Character codes
  localparam logic [7:0] WFL_CH_LF   = 8'h0A;             // Line feed
  localparam logic [7:0] WFL_CH_CR   = 8'h0D;             // Carriage return
  localparam logic [7:0] WFL_CH_CTL  = 8'h1F;             // Highest control code
  localparam logic [7:0] WFL_CH_STAR = 8'h2A;             // Field start
  localparam logic [7:0] WFL_CH_PCT  = 8'h25;             // File end
  // Field length limits
  localparam logic [9:0] WFL_CMT_MAX  = 10'h0FF;          // Comment chars, at most
  localparam logic [9:0] WFL_NAME_MAX = 10'h00F;          // Name chars, at most
  localparam logic [9:0] WFL_DATE_LEN = 10'h00A;          // Date chars, exact
  localparam logic [9:0] WFL_DATA_LEN = 10'h200;          // Hex chars, exact
  localparam logic [7:0] WFL_MIDPOINT = 8'h7F;            // Analog ground code
  // Frequency band limits in 0.1 Hz units
  localparam logic [17:0] WFL_BAND_0 = 18'h000A0;         // 16 Hz
  localparam logic [17:0] WFL_BAND_1 = 18'h00320;         // 80 Hz
  localparam logic [17:0] WFL_BAND_2 = 18'h00C80;         // 320 Hz
  localparam logic [17:0] WFL_BAND_3 = 18'h03200;         // 1280 Hz
  localparam logic [17:0] WFL_BAND_4 = 18'h0C800;         // 5120 Hz
  // Multiplexer channels
  localparam logic [2:0] WFL_SEL_COMMON = 3'h6;           // Common filter only
  localparam logic [2:0] WFL_SEL_GROUND = 3'h7;           // Grounded input
  // Register byte offsets
  localparam logic [7:0] WFL_OFS_CTRL = 8'h00;            // Output frequency
  localparam logic [7:0] WFL_OFS_STAT = 8'h04;            // Status
  localparam logic [7:0] WFL_OFS_FILT = 8'h08;            // Filter code
  localparam logic [7:0] WFL_OFS_SIDX = 8'h0C;            // Sample index
  localparam logic [7:0] WFL_OFS_SDAT = 8'h10;            // Sample data
  // Reset values
  localparam logic [17:0] WFL_FREQ_RST = 18'h02710;       // 1 kHz
  localparam logic [3:0]  WFL_CODE_RST = 4'h6;            // Common only
  // Status bit positions
  localparam int unsigned WFL_ST_HOST = 0;                // Host mode
  localparam int unsigned WFL_ST_DONE = 1;                // File accepted
  localparam int unsigned WFL_ST_ERR  = 2;                // File rejected
  // Received character
  typedef struct packed {
    logic       vld;                                      // One-cycle strobe
    logic [7:0] dat;                                      // Character code
  } wfl_char_t;
  // Receiver states
  typedef enum logic [1:0] {
    WFL_RX_IDLE  = 2'b00,
    WFL_RX_START = 2'b01,
    WFL_RX_DATA  = 2'b10,
    WFL_RX_STOP  = 2'b11
  } wfl_rx_t;
  // Parser states
  typedef enum logic [2:0] {
    WFL_P_CMT  = 3'b000,
    WFL_P_NAME = 3'b001,
    WFL_P_DATE = 3'b010,
    WFL_P_FILT = 3'b011,
    WFL_P_DATA = 3'b100,
    WFL_P_ERR  = 3'b101
  } wfl_ps_t;
endpackage

// ===== design/wfl_loader.sv
// Waveform file loader with filter channel select
// Function
// - Link is 9600 baud, 8N1, no flow
// - Host mode on RTS; panel switches ignored
// - Line feed and return are discarded
// - Other control characters flag file error
// - Data is 512 hex chars, 256 bytes
// - Hex digits accepted in either case
// - Percent sign ends the file
// - Samples offset around midpoint code
// - Three-bit select drives filter multiplexer
// - Channel from code and frequency band
// - Codes 0-6 pick code plus band
// - Code 7 ground, 8-D fixed, E-F invalid
// - Bypass switch forces common filter only
// - Clear-to-send follows request-to-send
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module wfl_loader
  import wfl_pkg::*;
#(
  parameter int unsigned BIT_CYC = WFL_BIT_CYC  // Cycles per serial bit
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        rts,
  output logic             cts,
  input  wire logic        sw_bypass,
  output logic      [2:0]  fsel
);
  localparam logic [12:0] BIT_END  = 13'(BIT_CYC - 1);     // Last cycle of bit
  localparam logic [12:0] HALF_END = 13'(BIT_CYC / 2 - 1); // Mid start bit

  // Reset release and pin synchronisers
  logic       rst_s1_q, rst_q;          // Reset release chain
  logic [1:0] rx_s_q, rts_s_q, byp_s_q; // Two-stage synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // Pins pass two flops before use
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_s_q  <= 2'b11;
      rts_s_q <= 2'b00;
      byp_s_q <= 2'b00;
    end else begin
      rx_s_q  <= {rx_s_q[0], rxd};
      rts_s_q <= {rts_s_q[0], rts};
      byp_s_q <= {byp_s_q[0], sw_bypass};
    end
  end
  wire rx_s  = rx_s_q[1];                // Serial data, synced
  wire rts_s = rts_s_q[1];               // Request to send, synced
  wire byp_s = byp_s_q[1];               // Bypass switch, synced

  // Host mode and clear-to-send loopback
  logic host_q;                          // Host mode flag
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      host_q <= 1'b0;
      cts    <= 1'b0;
    end else begin
      host_q <= rts_s;
      cts    <= rts_s;
    end
  end

  // Serial receiver, 8 data bits, one stop bit
  wfl_rx_t    rx_st_q;                   // Receiver state
  logic [12:0] rx_cnt_q;                 // Cycle count within bit
  logic [2:0]  rx_bit_q;                 // Data bit index
  logic [7:0]  rx_sh_q;                  // Shift register
  wfl_char_t   ch_q;                     // Received character strobe
  wire rx_bit_end = (rx_cnt_q == BIT_END);
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_st_q  <= WFL_RX_IDLE;
      rx_cnt_q <= 13'h0000;
      rx_bit_q <= 3'h0;
      rx_sh_q  <= 8'h00;
      ch_q     <= '0;
    end else begin
      ch_q.vld <= 1'b0;
      rx_cnt_q <= rx_bit_end ? 13'h0000 : rx_cnt_q + 13'h0001;
      unique case (rx_st_q)
        WFL_RX_IDLE: begin
          rx_cnt_q <= 13'h0000;
          if (!rx_s) rx_st_q <= WFL_RX_START;
        end
        WFL_RX_START: begin
          // Recheck start bit at its middle
          if (rx_cnt_q == HALF_END) begin
            rx_cnt_q <= 13'h0000;
            rx_bit_q <= 3'h0;
            rx_st_q  <= rx_s ? WFL_RX_IDLE : WFL_RX_DATA;
          end
        end
        WFL_RX_DATA: begin
          // LSB first, sampled mid bit
          if (rx_bit_end) begin
            rx_sh_q  <= {rx_s, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) rx_st_q <= WFL_RX_STOP;
          end
        end
        WFL_RX_STOP: begin
          // Framing errors drop the character
          if (rx_bit_end) begin
            ch_q.vld <= rx_s;
            ch_q.dat <= rx_sh_q;
            rx_st_q  <= WFL_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Character classes
  wire c_vld  = ch_q.vld & host_q;
  wire c_skip = (ch_q.dat == WFL_CH_LF) | (ch_q.dat == WFL_CH_CR);
  wire c_ctl  = (ch_q.dat <= WFL_CH_CTL) & ~c_skip;
  wire c_star = (ch_q.dat == WFL_CH_STAR);
  wire c_pct  = (ch_q.dat == WFL_CH_PCT);
  wire c_dig  = (ch_q.dat >= 8'h30) & (ch_q.dat <= 8'h39);
  wire c_up   = (ch_q.dat >= 8'h41) & (ch_q.dat <= 8'h46);
  wire c_lo   = (ch_q.dat >= 8'h61) & (ch_q.dat <= 8'h66);
  wire c_hex  = c_dig | c_up | c_lo;
  wire [3:0] c_nib = c_dig ? ch_q.dat[3:0] : 4'(ch_q.dat[3:0] + 4'h9);

  // File parser
  wfl_ps_t    ps_q;                      // Parser state
  logic [9:0] fcnt_q;                    // Characters in current field
  logic [3:0] hi_q;                      // High nibble of a sample
  logic [3:0] pcode_q;                   // Filter code being loaded
  logic [3:0] code_q;                    // Filter code of accepted file
  logic       done_q, err_q;             // Sticky file status
  logic [7:0] mem [256];                 // Sample store
  logic       set_done, set_err;         // Parser events
  wire [9:0]  fcnt_inc = fcnt_q + 10'h001;
  wire        code_bad = (c_nib >= 4'hE) | ~c_hex;
  always_comb begin
    set_done = 1'b0;
    set_err  = 1'b0;
    if (c_vld && !c_skip && ps_q != WFL_P_ERR) begin
      if (c_ctl) begin
        set_err = 1'b1;
      end else begin
        unique case (ps_q)
          WFL_P_CMT:  set_err = !c_star && fcnt_q == WFL_CMT_MAX;
          WFL_P_NAME: set_err = !c_star && fcnt_q == WFL_NAME_MAX;
          WFL_P_DATE: set_err = c_star ? fcnt_q != WFL_DATE_LEN
                                       : fcnt_q == WFL_DATE_LEN;
          WFL_P_FILT: set_err = c_star ? fcnt_q != 10'h001
                                       : (fcnt_q != 10'h000 || code_bad);
          WFL_P_DATA: begin
            set_done = c_pct && fcnt_q == WFL_DATA_LEN;
            set_err  = c_pct ? fcnt_q != WFL_DATA_LEN
                             : (!c_hex || fcnt_q == WFL_DATA_LEN);
          end
          default: set_err = 1'b0;
        endcase
      end
    end
  end

  // Parser state and field counters
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      ps_q    <= WFL_P_CMT;
      fcnt_q  <= 10'h000;
      hi_q    <= 4'h0;
      pcode_q <= WFL_CODE_RST;
      code_q  <= WFL_CODE_RST;
    end else if (!host_q) begin
      ps_q   <= WFL_P_CMT;
      fcnt_q <= 10'h000;
    end else if (set_err) begin
      ps_q <= WFL_P_ERR;
    end else if (set_done) begin
      ps_q   <= WFL_P_CMT;
      fcnt_q <= 10'h000;
      code_q <= pcode_q;
    end else if (c_vld && !c_skip) begin
      // Asterisk moves to the next field
      if (ps_q == WFL_P_ERR) begin
        if (c_pct) ps_q <= WFL_P_CMT;
        fcnt_q <= 10'h000;
      end else if (c_star && ps_q != WFL_P_DATA) begin
        ps_q   <= wfl_ps_t'(ps_q + 3'b001);
        fcnt_q <= 10'h000;
      end else begin
        fcnt_q <= fcnt_inc;
        if (ps_q == WFL_P_FILT) pcode_q <= c_nib;
        if (ps_q == WFL_P_DATA && !fcnt_q[0]) hi_q <= c_nib;
      end
    end
  end

  // Sample store, written on each low nibble
  always_ff @(posedge clk) begin
    if (c_vld && ps_q == WFL_P_DATA && c_hex && fcnt_q[0] && !set_err) begin
      mem[fcnt_q[8:1]] <= {hi_q, c_nib};
    end
  end

  // APB decode
  wire       acc   = psel & penable & pready;
  wire       wr    = acc & pwrite;
  wire       m_ctl = (paddr == WFL_OFS_CTRL);
  wire       m_st  = (paddr == WFL_OFS_STAT);
  wire       m_flt = (paddr == WFL_OFS_FILT);
  wire       m_idx = (paddr == WFL_OFS_SIDX);
  wire       m_dat = (paddr == WFL_OFS_SDAT);
  wire       mapped = m_ctl | m_st | m_flt | m_idx | m_dat;
  logic [17:0] freq_q;                   // Output frequency, 0.1 Hz units
  logic [7:0]  sidx_q;                   // Sample read index
  wire  [7:0]  samp = mem[sidx_q];
  wire  [8:0]  exc  = {1'b0, samp} - {1'b0, WFL_MIDPOINT};
  wire [31:0] rd_mux =
      m_ctl ? {14'h0000, freq_q} :
      m_st  ? {21'h000000, fsel, 5'h00, err_q, done_q, host_q} :
      m_flt ? {28'h0000000, code_q} :
      m_idx ? {24'h000000, sidx_q} :
      m_dat ? {7'h00, exc, 8'h00, samp} : 32'h00000000;

  // Bus slave with one wait state
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready) prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Software registers and sticky status, set wins over clear
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      freq_q <= WFL_FREQ_RST;
      sidx_q <= 8'h00;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      if (wr && m_ctl) freq_q <= pwdata[17:0];
      if (wr && m_idx) sidx_q <= pwdata[7:0];
      done_q <= set_done | (done_q & ~(wr & m_st & pwdata[WFL_ST_DONE]));
      err_q  <= set_err  | (err_q  & ~(wr & m_st & pwdata[WFL_ST_ERR]));
    end
  end

  // Band index and channel select
  wire [2:0] band = (freq_q <= WFL_BAND_0) ? 3'h0 :
                    (freq_q <= WFL_BAND_1) ? 3'h1 :
                    (freq_q <= WFL_BAND_2) ? 3'h2 :
                    (freq_q <= WFL_BAND_3) ? 3'h3 :
                    (freq_q <= WFL_BAND_4) ? 3'h4 : 3'h5;
  wire [3:0] bank  = {1'b0, code_q[2:0]} + {1'b0, band};
  wire       byp   = byp_s & ~host_q;
  wire [2:0] sel_d =
      byp                   ? WFL_SEL_COMMON :
      code_q == 4'h7        ? WFL_SEL_GROUND :
      code_q[3]             ? 3'(code_q - 4'h8) :
      bank > 4'h5           ? WFL_SEL_COMMON : bank[2:0];
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) fsel <= WFL_SEL_COMMON;
    else        fsel <= sel_d;
  end

  // Checks
  property p_cts;
    @(posedge clk) disable iff (!rst_q) cts == $past(rts, 3);
  endproperty
  a_cts: assert property (p_cts) else $error("cts not tracking rts");
  property p_skip;
    @(posedge clk) disable iff (!rst_q)
      (c_vld && c_skip && host_q && rts_s) |=> $stable(fcnt_q) && $stable(ps_q);
  endproperty
  a_skip: assert property (p_skip) else $error("line break altered parser");
  property p_ctl;
    @(posedge clk) disable iff (!rst_q) (c_vld && c_ctl && rts_s) |=> err_q;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control char not flagged");
  property p_end;
    @(posedge clk) disable iff (!rst_q)
      (c_vld && c_pct && ps_q == WFL_P_DATA && fcnt_q == WFL_DATA_LEN) |=> done_q;
  endproperty
  a_end: assert property (p_end) else $error("complete file not accepted");
  property p_gnd;
    @(posedge clk) disable iff (!rst_q)
      (code_q == 4'h7 && !byp) ##1 $stable(code_q) |-> fsel == WFL_SEL_GROUND;
  endproperty
  a_gnd: assert property (p_gnd) else $error("code 7 not grounded");
  property p_byp;
    @(posedge clk) disable iff (!rst_q) byp |=> fsel == WFL_SEL_COMMON;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass not honoured");
  property p_host;
    @(posedge clk) disable iff (!rst_q) !host_q |=> ps_q == WFL_P_CMT && fcnt_q == 10'h000;
  endproperty
  a_host: assert property (p_host) else $error("parser active outside host");
  property p_low;
    @(posedge clk) disable iff (!rst_q)
      (code_q == 4'h1 && !byp && freq_q <= WFL_BAND_0) ##1 $stable(freq_q)
      && $stable(code_q) |-> fsel == 3'h1;
  endproperty
  a_low: assert property (p_low) else $error("bank select wrong");
endmodule

// ===== bench/wfl_host_model.sv
// Host terminal model: serial line and request-to-send
`timescale 1ns/10ps
module wfl_host_model #(
  parameter int unsigned BIT_CYC = 16  // Cycles per serial bit
) (
  input  wire logic clk,
  output logic      rxd,
  output logic      rts
);
  // Line idles at mark, host mode off
  initial begin
    rxd = 1'b1;
    rts = 1'b0;
  end
  // Request-to-send level, changed just after an edge
  task automatic set_rts(input logic v);
    rts <= v;
  endtask
  // One character: start, eight bits LSB first, stop, no parity
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  // Characters of a string in order
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_char(s[i]);
    end
  endtask
  // Nibble to hex character, either case
  function automatic logic [7:0] hx(input logic [3:0] n, input logic lc);
    if (n < 4'hA) return 8'h30 + n;
    return (lc ? 8'h61 : 8'h41) + n - 8'h0A;
  endfunction
  // Comment, fields in order, each opened by an asterisk
  task automatic send_head(input logic [7:0] code);
    send_str("Ramp test\r\n*RAMP\r\n*2022-08-30\r\n*");
    send_char(code);
    send_str("\r\n*\r\n");
  endtask
  // Sample k is k; pairs kept whole, breaks only between pairs
  task automatic send_data();
    for (int k = 0; k < 256; k++) begin
      send_char(hx(k[7:4], k[0]));
      send_char(hx(k[3:0], k[0]));
      if (k[3:0] == 4'hF) send_str("\r\n");
    end
    send_char(8'h25);
  endtask
endmodule

// ===== bench/tb_waveform_file_loader_filter_select.sv
// Testbench for the waveform file loader
`timescale 1ns/10ps
module tb_waveform_file_loader_filter_select
  import wfl_pkg::*;
;
  localparam int unsigned BC = 4;       // Short bit time for simulation
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;                   // Register address
  logic [31:0] pwdata, prdata, rd;      // Bus data and last read
  logic        rxd, rts, cts, sw_bypass;
  logic        rerr;                    // Error response of last transfer
  logic [2:0]  fsel;                    // Multiplexer channel
  int          n_mismatch, n_compared;  // Report counters
  wfl_loader #(.BIT_CYC(BC)) dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .rts(rts), .cts(cts), .sw_bypass(sw_bypass), .fsel(fsel));
  wfl_host_model #(.BIT_CYC(BC)) host (.clk(clk), .rxd(rxd), .rts(rts));
  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Result compare
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) cmp({31'h0, pready}, 32'h1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps a following request off this edge
    @(posedge clk);
  endtask
  // Read and compare under a mask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd & m, e);
  endtask
  // Reset values, read-only and unmapped places
  task automatic t_reset();
    rchk(WFL_OFS_CTRL, 32'hFFFFFFFF, 32'h00002710);
    apb(1'b1, WFL_OFS_FILT, 32'h00000003);
    rchk(WFL_OFS_FILT, 32'hFFFFFFFF, 32'h00000006);
    rchk(WFL_OFS_STAT, 32'hFFFFFFFF, 32'h00000600);
    cmp({31'h0, rerr}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    cmp(rd, 32'h0);
    cmp({28'h0, cts, fsel}, 32'h6);
  endtask
  // Host mode entry and clear-to-send loop
  task automatic t_host();
    host.set_rts(1'b1);
    repeat (6) @(posedge clk);
    cmp({31'h0, cts}, 32'h1);
    rchk(WFL_OFS_STAT, 32'h7, 32'h1);
  endtask
  // Whole file with breaks and mixed-case hex
  task automatic t_file();
    host.send_head(8'h31);
    host.send_data();
    repeat (10) @(posedge clk);
    rchk(WFL_OFS_STAT, 32'h7, 32'h3);
    rchk(WFL_OFS_FILT, 32'hF, 32'h1);
    for (int k = 5; k < 256; k += 83) begin
      apb(1'b1, WFL_OFS_SIDX, k);
      rchk(WFL_OFS_SDAT, 32'h01FF00FF, {7'h0, 9'(k) - 9'h07F, 8'h0, 8'(k)});
    end
  endtask
  // Band boundaries with filter code one
  task automatic t_bands();
    logic [17:0] fq [7] = '{18'd160, 18'd161, 18'd800, 18'd801, 18'd3201, 18'd12801, 18'd51201};
    int          bd [7] = '{0, 1, 1, 2, 3, 4, 5};
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, WFL_OFS_CTRL, {14'h0, fq[i]});
      repeat (3) @(posedge clk);
      cmp(fsel, (1 + bd[i] > 5) ? 3'h6 : 3'(1 + bd[i]));
    end
  endtask
  // Malformed files raise the error flag, filter code kept
  task automatic t_errors();
    string bad [5] = '{"*N\001", "*ABCDEFGHIJKLMNOP*", "*N*2022-8-30*",
                       "*N*2022-08-30*E*", "*N*2022-08-30*1*0g"};
    apb(1'b1, WFL_OFS_STAT, 32'h6);
    for (int i = 0; i < 5; i++) begin
      host.send_str(bad[i]);
      repeat (10) @(posedge clk);
      rchk(WFL_OFS_STAT, 32'h6, 32'h4);
      host.send_char(8'h25);
      apb(1'b1, WFL_OFS_STAT, 32'h4);
      rchk(WFL_OFS_STAT, 32'h4, 32'h0);
    end
    rchk(WFL_OFS_FILT, 32'hF, 32'h1);
  endtask
  // Grounded code, then a fixed bank code in lower case
  task automatic t_fixed();
    host.send_head(8'h37);
    host.send_data();
    repeat (10) @(posedge clk);
    rchk(WFL_OFS_FILT, 32'hF, 32'h7);
    cmp(fsel, WFL_SEL_GROUND);
    host.send_head(8'h63);
    host.send_data();
    repeat (10) @(posedge clk);
    cmp(fsel, 32'h4);
    apb(1'b1, WFL_OFS_CTRL, 32'd160);
    repeat (3) @(posedge clk);
    cmp(fsel, 32'h4);
  endtask
  // Bypass switch ignored in host mode, obeyed outside it
  task automatic t_bypass();
    apb(1'b1, WFL_OFS_CTRL, 32'd160);
    sw_bypass <= 1'b1;
    repeat (6) @(posedge clk);
    cmp(fsel, 3'h4);
    host.set_rts(1'b0);
    repeat (6) @(posedge clk);
    cmp({28'h0, cts, fsel}, 32'h6);
    sw_bypass <= 1'b0;
    repeat (6) @(posedge clk);
    cmp(fsel, 3'h4);
  endtask
  // Counts and verdict, then end of run
  task automatic print_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {psel, penable, pwrite, sw_bypass} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_host();
    t_file();
    t_bands();
    t_errors();
    t_fixed();
    t_bypass();
    print_verdict();
  end
endmodule
